// ==== hdl/bus_minor_cycle_sequencer.v ====
// Purpose: bus controller unit that walks a list of instruction pairs
// Assumes: host writes pairs and registers over AXI4-Lite
// Notes:   list memory and pointer are frozen while running
//
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "bus_minor_cycle_sequencer_defines.vh"
module bus_minor_cycle_sequencer #(
	parameter MEM_AW = 8
) (
	// clock and reset
	input  wire        core_clk_in,
	input  wire        arst_n_in,
	// axi4-lite write address and data
	input  wire        s_axi_awvalid_in,
	output reg         s_axi_awready_out,
	input  wire [11:0] s_axi_awaddr_in,
	input  wire        s_axi_wvalid_in,
	output reg         s_axi_wready_out,
	input  wire [31:0] s_axi_wdata_in,
	input  wire [3:0]  s_axi_wstrb_in,
	// axi4-lite write response
	output reg         s_axi_bvalid_out,
	input  wire        s_axi_bready_in,
	output reg  [1:0]  s_axi_bresp_out,
	// axi4-lite read
	input  wire        s_axi_arvalid_in,
	output reg         s_axi_arready_out,
	input  wire [11:0] s_axi_araddr_in,
	output reg         s_axi_rvalid_out,
	input  wire        s_axi_rready_in,
	output reg  [31:0] s_axi_rdata_out,
	output reg  [1:0]  s_axi_rresp_out,
	// serial bus terminal
	input  wire        xfer_done_in,
	input  wire        xfer_ok_in,
	output wire        xfer_req_out,
	output wire [1:0]  xfer_kind_out,
	output wire        xfer_bus_sel_out,
	output wire [15:0] xfer_word0_out,
	output wire [15:0] xfer_word1_out,
	output wire [15:0] xfer_mask_out,
	// host interrupt
	output reg         pci_out
);

localparam [5:0] ST_IDLE  = 6'b000001;
localparam [5:0] ST_SYNC  = 6'b000010;
localparam [5:0] ST_SWAIT = 6'b000100;
localparam [5:0] ST_FETCH = 6'b001000;
localparam [5:0] ST_EXEC  = 6'b010000;
localparam [5:0] ST_WAIT  = 6'b100000;
localparam [MEM_AW-1:0] STEP1 = 1;
localparam [MEM_AW-1:0] STEP2 = 2;

reg  [15:0]       mem [0:(1<<MEM_AW)-1];
reg               rst_meta;
reg               rst_n;
reg  [5:0]        state;
reg  [MEM_AW-1:0] pc;
reg  [15:0]       w0;
reg  [15:0]       w1;
reg  [MEM_AW-1:0] start_ptr;
reg  [5:0]        minor_num;
reg  [15:0]       mode_data;
reg               st_done;
reg               st_pci;
reg               st_fault;
reg               aw_held;
reg               w_held;
reg  [11:0]       aw_addr;
reg  [31:0]       w_data;
reg  [3:0]        w_strb;
reg               next_aw_held;
reg               next_w_held;
reg               next_bvalid;
reg               next_rvalid;
reg               do_write;
reg  [31:0]       rd_val;
reg  [1:0]        rd_resp;
reg  [1:0]        wr_resp;
reg               x_start;
reg  [1:0]        x_kind;
wire              running;
wire [15:0]       wmask;
wire [15:0]       wval;
wire              is_mem_wr;
wire [MEM_AW-1:0] wr_idx;
wire              ctrl_wr;
wire              stat_wr;
wire              start_req;
wire              abort_req;
wire              x_ok;
wire              x_fail;

// --------------------------------------------------------------
// reset release
// --------------------------------------------------------------
// async assert, two-flop synchronous release
always @(posedge core_clk_in or negedge arst_n_in) begin
	if (!arst_n_in) begin
		rst_meta <= 1'b0;
		rst_n    <= 1'b0;
	end else begin
		rst_meta <= 1'b1;
		rst_n    <= rst_meta;
	end
end

// --------------------------------------------------------------
// axi4-lite handshakes
// --------------------------------------------------------------
assign running   = (state != ST_IDLE);
assign wmask     = {{8{w_strb[1]}}, {8{w_strb[0]}}};
assign wval      = w_data[15:0];
assign is_mem_wr = (aw_addr[11:10] == `MEM_SEL);
assign wr_idx    = aw_addr[MEM_AW+1:2];
assign ctrl_wr   = do_write && (aw_addr == `REG_CTRL) && w_strb[0];
assign stat_wr   = do_write && (aw_addr == `REG_STATUS) && w_strb[0];
assign start_req = ctrl_wr && w_data[`CTRL_START];
assign abort_req = ctrl_wr && w_data[`CTRL_ABORT];

// address and data are taken in either order, answered once both
always @* begin
	next_aw_held = aw_held;
	next_w_held  = w_held;
	do_write     = aw_held && w_held && !s_axi_bvalid_out;
	if (do_write) begin
		next_aw_held = 1'b0;
		next_w_held  = 1'b0;
	end
	if (s_axi_awvalid_in && s_axi_awready_out)
		next_aw_held = 1'b1;
	if (s_axi_wvalid_in && s_axi_wready_out)
		next_w_held = 1'b1;
	next_bvalid = (s_axi_bvalid_out && !s_axi_bready_in) || do_write;
	next_rvalid = (s_axi_rvalid_out && !s_axi_rready_in) ||
		(s_axi_arvalid_in && s_axi_arready_out);
end

// write response code: list and pointers locked while running
always @* begin
	wr_resp = `RESP_OKAY;
	if (is_mem_wr) begin
		if (running)
			wr_resp = `RESP_SLVERR;
	end else begin
		case (aw_addr)
			`REG_CTRL, `REG_STATUS: wr_resp = `RESP_OKAY;
			`REG_START_PTR, `REG_FUNC, `REG_MODE_DATA:
				wr_resp = running ? `RESP_SLVERR : `RESP_OKAY;
			`REG_PC: wr_resp = `RESP_SLVERR;
			default: wr_resp = `RESP_DECERR;
		endcase
	end
end

always @(posedge core_clk_in or negedge rst_n) begin
	if (!rst_n) begin
		aw_held           <= 1'b0;
		w_held            <= 1'b0;
		aw_addr           <= 12'h000;
		w_data            <= 32'h00000000;
		w_strb            <= 4'h0;
		s_axi_awready_out <= 1'b0;
		s_axi_wready_out  <= 1'b0;
		s_axi_bvalid_out  <= 1'b0;
		s_axi_bresp_out   <= `RESP_OKAY;
		s_axi_arready_out <= 1'b0;
		s_axi_rvalid_out  <= 1'b0;
		s_axi_rdata_out   <= 32'h00000000;
		s_axi_rresp_out   <= `RESP_OKAY;
	end else begin
		aw_held           <= next_aw_held;
		w_held            <= next_w_held;
		s_axi_bvalid_out  <= next_bvalid;
		s_axi_rvalid_out  <= next_rvalid;
		s_axi_awready_out <= !next_aw_held && !next_bvalid;
		s_axi_wready_out  <= !next_w_held && !next_bvalid;
		s_axi_arready_out <= !next_rvalid;
		if (s_axi_awvalid_in && s_axi_awready_out)
			aw_addr <= s_axi_awaddr_in;
		if (s_axi_wvalid_in && s_axi_wready_out) begin
			w_data <= s_axi_wdata_in;
			w_strb <= s_axi_wstrb_in;
		end
		if (do_write)
			s_axi_bresp_out <= wr_resp;
		if (s_axi_arvalid_in && s_axi_arready_out) begin
			s_axi_rdata_out <= rd_val;
			s_axi_rresp_out <= rd_resp;
		end
	end
end

// --------------------------------------------------------------
// read mux
// --------------------------------------------------------------
// memory reads stay open while running, for debug
always @* begin
	rd_val  = 32'h00000000;
	rd_resp = `RESP_OKAY;
	if (s_axi_araddr_in[11:10] == `MEM_SEL) begin
		rd_val = {16'h0000, mem[s_axi_araddr_in[MEM_AW+1:2]]};
	end else begin
		case (s_axi_araddr_in)
			`REG_CTRL:      rd_val = 32'h00000000;
			`REG_START_PTR: rd_val[MEM_AW-1:0] = start_ptr;
			`REG_FUNC:      rd_val[5:0] = minor_num;
			`REG_MODE_DATA: rd_val[15:0] = mode_data;
			`REG_STATUS: begin
				rd_val[`STAT_RUN]   = running;
				rd_val[`STAT_DONE]  = st_done;
				rd_val[`STAT_PCI]   = st_pci;
				rd_val[`STAT_FAULT] = st_fault;
			end
			`REG_PC:        rd_val[MEM_AW-1:0] = pc;
			default:        rd_resp = `RESP_DECERR;
		endcase
	end
end

// --------------------------------------------------------------
// host-visible configuration
// --------------------------------------------------------------
// pointer, minor cycle number and mask change only between cycles
always @(posedge core_clk_in or negedge rst_n) begin
	if (!rst_n) begin
		start_ptr <= `RST_START_PTR;
		minor_num <= `RST_FUNC;
		mode_data <= `RST_MODE;
	end else if (do_write && !running) begin
		case (aw_addr)
			`REG_START_PTR: start_ptr <= (start_ptr & ~wmask[MEM_AW-1:0]) |
				(wval[MEM_AW-1:0] & wmask[MEM_AW-1:0]);
			`REG_FUNC:      minor_num <= (minor_num & ~wmask[5:0]) |
				(wval[5:0] & wmask[5:0]);
			`REG_MODE_DATA: mode_data <= (mode_data & ~wmask) |
				(wval & wmask);
			default:        mode_data <= mode_data;
		endcase
	end
end

// instruction list memory, written by the host while halted
always @(posedge core_clk_in) begin
	if (do_write && is_mem_wr && !running)
		mem[wr_idx] <= (mem[wr_idx] & ~wmask) | (wval & wmask);
end

// --------------------------------------------------------------
// sequencer
// --------------------------------------------------------------
always @(posedge core_clk_in or negedge rst_n) begin
	if (!rst_n) begin
		state    <= ST_IDLE;
		pc       <= {MEM_AW{1'b0}};
		w0       <= 16'h0000;
		w1       <= 16'h0000;
		x_start  <= 1'b0;
		x_kind   <= `KIND_DATA;
		pci_out  <= 1'b0;
		st_done  <= 1'b0;
		st_pci   <= 1'b0;
		st_fault <= 1'b0;
	end else begin
		x_start <= 1'b0;
		pci_out <= 1'b0;
		// sticky flags: a set in the clear cycle wins
		if (stat_wr) begin
			st_done  <= st_done & ~w_data[`STAT_DONE];
			st_pci   <= st_pci & ~w_data[`STAT_PCI];
			st_fault <= st_fault & ~w_data[`STAT_FAULT];
		end
		if (abort_req && running) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: begin
					if (start_req) begin
						pc    <= start_ptr;
						state <= ST_SYNC;
					end
				end
				// sync command carries the minor cycle number
				ST_SYNC: begin
					x_kind  <= `KIND_SYNC;
					w0      <= {10'h000, minor_num};
					w1      <= 16'h0000;
					x_start <= 1'b1;
					state   <= ST_SWAIT;
				end
				ST_SWAIT: begin
					if (x_ok)
						state <= ST_FETCH;
					else if (x_fail) begin
						st_fault <= 1'b1;
						state    <= ST_IDLE;
					end
				end
				ST_FETCH: begin
					w0    <= mem[pc];
					w1    <= mem[pc + STEP1];
					state <= ST_FETCH << 1;
				end
				ST_EXEC: begin
					case (w0[`F_OP_HI:`F_OP_LO])
						`OP_HALT: begin
							st_done <= 1'b1;
							state   <= ST_IDLE;
						end
						`OP_LINK: begin
							pc    <= w1[MEM_AW-1:0];
							state <= ST_FETCH;
						end
						`OP_NOP: begin
							pc    <= pc + STEP2;
							state <= ST_FETCH;
						end
						default: begin
							x_kind  <= w0[`F_MODE] ? `KIND_MODE : `KIND_DATA;
							x_start <= 1'b1;
							state   <= ST_WAIT;
						end
					endcase
				end
				ST_WAIT: begin
					if (x_ok) begin
						// interrupt only on a completed transfer
						if (w0[`F_IRQ]) begin
							pci_out <= 1'b1;
							st_pci  <= 1'b1;
						end
						pc    <= pc + STEP2;
						state <= ST_FETCH;
					end else if (x_fail) begin
						// retries used up: stop, leave pc on the pair
						st_fault <= 1'b1;
						state    <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end
end

// --------------------------------------------------------------
// transfer engine
// --------------------------------------------------------------
xfer_engine u_xfer (
	.clk_in      (core_clk_in),
	.rst_n_in    (rst_n),
	.start_in    (x_start),
	.abort_in    (abort_req),
	.kind_in     (x_kind),
	.bus_sel_in  (w0[`F_BUS]),
	.word0_in    (w0),
	.word1_in    (w1),
	.mask_in     (mode_data),
	.retry_in    (w0[`F_RETRY_HI:`F_RETRY_LO]),
	.ok_out      (x_ok),
	.fail_out    (x_fail),
	.done_in     (xfer_done_in),
	.ok_in       (xfer_ok_in),
	.req_out     (xfer_req_out),
	.kind_out    (xfer_kind_out),
	.bus_sel_out (xfer_bus_sel_out),
	.word0_out   (xfer_word0_out),
	.word1_out   (xfer_word1_out),
	.mask_out    (xfer_mask_out)
);

endmodule

// ==== hdl/bus_minor_cycle_sequencer_defines.vh ====
// Purpose: constants for the bus minor cycle sequencer
// Assumes: 16-bit instruction words, AXI4-Lite register access
// Notes:   offsets are byte addresses, all word aligned
`ifndef BUS_MINOR_CYCLE_SEQUENCER_DEFINES_VH
`define BUS_MINOR_CYCLE_SEQUENCER_DEFINES_VH

// --------------------------------------------------------------
// register map
// --------------------------------------------------------------
`define REG_CTRL      12'h000
`define REG_START_PTR 12'h004
`define REG_FUNC      12'h008
`define REG_MODE_DATA 12'h00C
`define REG_STATUS    12'h010
`define REG_PC        12'h014
`define MEM_SEL       2'h1

// --------------------------------------------------------------
// register fields and reset values
// --------------------------------------------------------------
`define CTRL_START  0
`define CTRL_ABORT  1
`define STAT_RUN    0
`define STAT_DONE   1
`define STAT_PCI    2
`define STAT_FAULT  3
`define RST_START_PTR 8'h00
`define RST_FUNC    6'h00
`define RST_MODE    16'h0000

// --------------------------------------------------------------
// instruction word fields
// --------------------------------------------------------------
`define F_OP_HI     15
`define F_OP_LO     14
`define F_RETRY_HI  13
`define F_RETRY_LO  12
`define F_BUS       11
`define F_IRQ       10
`define F_MODE      9
`define OP_HALT     2'h0
`define OP_LINK     2'h1
`define OP_NOP      2'h2
`define OP_BUS      2'h3
`define RETRY_MAX   2'h3

// --------------------------------------------------------------
// transfer kinds and bus responses
// --------------------------------------------------------------
`define KIND_DATA   2'h0
`define KIND_MODE   2'h1
`define KIND_SYNC   2'h2
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2
`define RESP_DECERR 2'h3

`endif

// ==== hdl/xfer_engine.v ====
// Purpose: issues one bus transfer and retries it on failure
// Assumes: terminal pulses done_in with ok_in on the same clock
// Notes:   request is dropped a cycle between tries
`timescale 1ns/1ps
`include "bus_minor_cycle_sequencer_defines.vh"
module xfer_engine (
	// clock and reset
	input  wire        clk_in,
	input  wire        rst_n_in,
	// sequencer side
	input  wire        start_in,
	input  wire        abort_in,
	input  wire [1:0]  kind_in,
	input  wire        bus_sel_in,
	input  wire [15:0] word0_in,
	input  wire [15:0] word1_in,
	input  wire [15:0] mask_in,
	input  wire [1:0]  retry_in,
	output reg         ok_out,
	output reg         fail_out,
	// terminal side
	input  wire        done_in,
	input  wire        ok_in,
	output reg         req_out,
	output reg  [1:0]  kind_out,
	output reg         bus_sel_out,
	output reg  [15:0] word0_out,
	output reg  [15:0] word1_out,
	output reg  [15:0] mask_out
);

reg        busy;
reg        again;
reg  [1:0] tries;
reg  [1:0] limit;

// --------------------------------------------------------------
// request, result and retry counting
// --------------------------------------------------------------
always @(posedge clk_in or negedge rst_n_in) begin
	if (!rst_n_in) begin
		busy        <= 1'b0;
		again       <= 1'b0;
		tries       <= 2'h0;
		limit       <= 2'h0;
		ok_out      <= 1'b0;
		fail_out    <= 1'b0;
		req_out     <= 1'b0;
		kind_out    <= `KIND_DATA;
		bus_sel_out <= 1'b0;
		word0_out   <= 16'h0000;
		word1_out   <= 16'h0000;
		mask_out    <= 16'h0000;
	end else begin
		ok_out   <= 1'b0;
		fail_out <= 1'b0;
		again    <= 1'b0;
		if (abort_in) begin
			busy    <= 1'b0;
			req_out <= 1'b0;
		end else if (start_in && !busy) begin
			busy        <= 1'b1;
			req_out     <= 1'b1;
			tries       <= 2'h0;
			kind_out    <= kind_in;
			bus_sel_out <= bus_sel_in;
			word0_out   <= word0_in;
			word1_out   <= word1_in;
			mask_out    <= mask_in;
			// clamp is a hard stop even if the field widens
			limit <= (retry_in > `RETRY_MAX) ? `RETRY_MAX : retry_in;
		end else if (again) begin
			req_out <= 1'b1;
		end else if (busy && req_out && done_in) begin
			req_out <= 1'b0;
			if (ok_in) begin
				busy   <= 1'b0;
				ok_out <= 1'b1;
			end else if (tries < limit) begin
				tries <= tries + 2'h1;
				again <= 1'b1;
			end else begin
				busy     <= 1'b0;
				fail_out <= 1'b1;
			end
		end
	end
end

endmodule

// ==== verif/bus_minor_cycle_sequencer_tb.sv ====
// Purpose: self-checking bench for the minor cycle sequencer
// Assumes: remote node model answers every transfer
// Notes:   expected transfers are queued as the list is written
`timescale 1ns/1ps
`include "bus_minor_cycle_sequencer_defines.vh"
module bus_minor_cycle_sequencer_tb;
	reg         clk, rst_n, awv, wv, bry, arv, rry, req_d;
	reg  [11:0] awa, ara;
	reg  [31:0] wd, d;
	reg  [1:0]  fmode;
	reg  [15:0] mval, r;
	wire        awr, wr, bv, arr, rv, done, ok, req, bsel, pci;
	wire [1:0]  br, rr, kind;
	wire [31:0] rd;
	wire [15:0] w0, w1, mask;
	integer     fails, num_checks, n_try, n_pci, cyc, i;
	reg  [1:0]  q_kind[$];
	reg  [15:0] q_w0[$], q_w1[$];

	bus_minor_cycle_sequencer #(.MEM_AW(8)) dut (
		.core_clk_in(clk), .arst_n_in(rst_n),
		.s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
		.s_axi_awaddr_in(awa), .s_axi_wvalid_in(wv),
		.s_axi_wready_out(wr), .s_axi_wdata_in(wd),
		.s_axi_wstrb_in(4'hF), .s_axi_bvalid_out(bv),
		.s_axi_bready_in(bry), .s_axi_bresp_out(br),
		.s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
		.s_axi_araddr_in(ara), .s_axi_rvalid_out(rv),
		.s_axi_rready_in(rry), .s_axi_rdata_out(rd),
		.s_axi_rresp_out(rr), .xfer_done_in(done), .xfer_ok_in(ok),
		.xfer_req_out(req), .xfer_kind_out(kind),
		.xfer_bus_sel_out(bsel), .xfer_word0_out(w0),
		.xfer_word1_out(w1), .xfer_mask_out(mask), .pci_out(pci));
	remote_node_model partner (.clk_in(clk), .rst_n_in(rst_n),
		.req_in(req), .kind_in(kind), .word0_in(w0),
		.fail_mode_in(fmode), .done_out(done), .ok_out(ok));

	// --------------------------------------------------------------
	// checking and bus tasks
	// --------------------------------------------------------------
	task chk(input [8*8-1:0] nm, input [31:0] seen, input [31:0] exp);
		begin
			num_checks = num_checks + 1;
			if (seen !== exp) begin
				fails = fails + 1;
				$display("MISMATCH %0s exp %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task complete_run;
		begin
			$display("checks %0d mismatches %0d", num_checks, fails);
			if (fails == 0 && num_checks > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	// address and data offered together, each released when taken
	task axi_wr(input [11:0] a, input [31:0] v, input [1:0] er);
		reg fin;
		begin
			fin = 1'b0;
			@(posedge clk);
			{awv, wv, bry} <= 3'h7;
			awa <= a;
			wd <= v;
			while (!fin) begin
				@(posedge clk);
				if (awv && awr) awv <= 1'b0;
				if (wv && wr) wv <= 1'b0;
				if (bv && bry) begin
					fin = 1'b1;
					bry <= 1'b0;
					chk("bresp", br, er);
				end
			end
		end
	endtask
	task axi_rd(input [11:0] a, input [1:0] er, output [31:0] v);
		reg fin;
		begin
			fin = 1'b0;
			@(posedge clk);
			{arv, rry} <= 2'h3;
			ara <= a;
			while (!fin) begin
				@(posedge clk);
				if (arv && arr) arv <= 1'b0;
				if (rv && rry) begin
					fin = 1'b1;
					rry <= 1'b0;
					v = rd;
					chk("rresp", rr, er);
				end
			end
		end
	endtask
	task expect_xfer(input [1:0] k, input [15:0] a, input [15:0] b);
		begin
			q_kind.push_back(k);
			q_w0.push_back(a);
			q_w1.push_back(b);
		end
	endtask
	// kind 3 marks a pair that moves nothing on the bus
	task put_pair(input [7:0] x, input [15:0] a, input [15:0] b,
		input [1:0] k);
		begin
			axi_wr(12'h400 + {2'h0, x, 2'h0}, {16'h0, a}, `RESP_OKAY);
			axi_wr(12'h404 + {2'h0, x, 2'h0}, {16'h0, b}, `RESP_OKAY);
			if (k != 2'h3) expect_xfer(k, a, b);
		end
	endtask
	task wait_idle;
		begin
			d = 32'h1;
			for (i = 0; i < 200 && d[0] !== 1'b0; i = i + 1)
				axi_rd(`REG_STATUS, `RESP_OKAY, d);
		end
	endtask

	// --------------------------------------------------------------
	// clock, timeout and transfer monitor
	// --------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// each try is compared with the head of the expected list
	always @(posedge clk) begin
		cyc <= cyc + 1;
		req_d <= req;
		if (pci) n_pci = n_pci + 1;
		if (req && !req_d) begin
			n_try = n_try + 1;
			if (q_kind.size() == 0) chk("extra", 1, 0);
			else begin
				chk("kind", kind, q_kind[0]);
				chk("word0", w0, q_w0[0]);
				if (q_kind[0] != 2'h2) chk("word1", w1, q_w1[0]);
				if (q_kind[0] != 2'h2) chk("bus", bsel, q_w0[0][11]);
				if (q_kind[0] == 2'h1) chk("mask", mask, mval);
			end
		end
		if (req && done && ok && q_kind.size() > 0) begin
			void'(q_kind.pop_front());
			void'(q_w0.pop_front());
			void'(q_w1.pop_front());
		end
		// the ceiling is last so nothing runs after the verdict
		if (cyc == 20000) begin
			fails = fails + 1;
			complete_run;
		end
	end

	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial begin
		{rst_n, awv, wv, bry, arv, rry, req_d, fmode} = 9'h0;
		{awa, ara, wd} = 56'h0;
		{fails, num_checks, n_try, n_pci, cyc} = 160'h0;
		r = $urandom(32'h7d6acf09);
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		for (i = 0; i < 6; i = i + 1) begin
			axi_rd({7'h0, i[2:0], 2'h0}, `RESP_OKAY, d);
			chk("reset", d, 32'h0);
		end
		axi_rd(12'h020, `RESP_DECERR, d);
		chk("unmapd", d, 32'h0);
		axi_wr(`REG_PC, 32'h1, `RESP_SLVERR);
		axi_wr(12'h024, 32'h1, `RESP_DECERR);
		mval = $urandom;
		axi_wr(`REG_MODE_DATA, {16'h0, mval}, `RESP_OKAY);
		axi_wr(`REG_FUNC, 32'd43, `RESP_OKAY);
		axi_rd(`REG_FUNC, `RESP_OKAY, d);
		chk("func", d, 32'd43);
		expect_xfer(2'h2, 16'd43, 16'h0);
		// mode command, flagged retried transfer, nop, link, plain one
		r = $urandom;
		put_pair(8'd0, 16'hCA00 | (r & 16'h01FF), ~r, 2'h1);
		put_pair(8'd2, 16'hDC00 | (r & 16'h01FF), r, 2'h0);
		put_pair(8'd4, 16'h8000, r, 2'h3);
		// phase of minor cycle 43 for period 2 picks the block at 8 or 10
		d = 32'd8 + 32'd2 * (32'd43 % 32'd2);
		put_pair(8'd6, 16'h4000, d[15:0], 2'h3);
		put_pair(8'd10, 16'hC000 | (r & 16'h01FF), {r[7:0], r[15:8]},
			2'h0);
		put_pair(8'd12, 16'h0000, 16'h0, 2'h3);
		fmode <= 2'h1;
		axi_wr(`REG_START_PTR, 32'h0, `RESP_OKAY);
		axi_wr(`REG_CTRL, 32'h1, `RESP_OKAY);
		wait_idle;
		chk("status", d, 32'h6);
		chk("pending", q_kind.size(), 0);
		chk("tries", n_try, 5);
		chk("pci", n_pci, 1);
		axi_wr(`REG_STATUS, 32'hE, `RESP_OKAY);
		axi_rd(`REG_STATUS, `RESP_OKAY, d);
		chk("clear", d, 32'h0);
		// a transfer that never succeeds stops after three retries
		fmode <= 2'h2;
		axi_wr(`REG_FUNC, 32'd63, `RESP_OKAY);
		expect_xfer(2'h2, 16'd63, 16'h0);
		put_pair(8'd20, 16'hF800 | (r & 16'h01FF), r, 2'h0);
		put_pair(8'd22, 16'h0000, 16'h0, 2'h3);
		axi_wr(`REG_START_PTR, 32'd20, `RESP_OKAY);
		axi_wr(`REG_CTRL, 32'h1, `RESP_OKAY);
		axi_wr(`REG_START_PTR, 32'h5, `RESP_SLVERR);
		wait_idle;
		chk("status", d, 32'h8);
		chk("tries", n_try, 10);
		chk("pci", n_pci, 1);
		axi_rd(`REG_START_PTR, `RESP_OKAY, d);
		chk("ptr", d, 32'd20);
		complete_run;
	end
endmodule

// ==== verif/remote_node_model.sv ====
// Purpose: remote node answering each bus transfer try
// Assumes: one answer per request, random wait of 0 to 3 cycles
// Notes:   mode 1 fails first try of any transfer with a nonzero retry field, mode 2 fails data
`timescale 1ns/1ps
module remote_node_model (
	// clock and reset
	input  wire        clk_in,
	input  wire        rst_n_in,
	// transfer request
	input  wire        req_in,
	input  wire [1:0]  kind_in,
	input  wire [15:0] word0_in,
	input  wire [1:0]  fail_mode_in,
	// answer
	output reg         done_out,
	output reg         ok_out
);
	integer wait_cnt;
	reg     busy;
	reg     failed_last;
	wire    pass = !(fail_mode_in == 2'h2 && kind_in == 2'h0) &&
		!(fail_mode_in == 2'h1 && word0_in[13:12] != 2'h0 && !failed_last);

	// ok toggles while idle so a stale value is never trusted
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			done_out <= 1'b0;
			ok_out <= 1'b0;
			busy <= 1'b0;
			failed_last <= 1'b0;
			wait_cnt <= 0;
		end else begin
			done_out <= 1'b0;
			ok_out <= ~ok_out;
			if (busy) begin
				if (!req_in)
					busy <= 1'b0;
			end else if (req_in) begin
				if (wait_cnt == 0) begin
					done_out <= 1'b1;
					ok_out <= pass;
					busy <= 1'b1;
					failed_last <= ~pass;
					wait_cnt <= $urandom % 4;
				end else
					wait_cnt <= wait_cnt - 1;
			end
		end
	end
endmodule

// ==== verif/seq_checker_assertions.sv ====
// Purpose: concurrent checks on the sequencer top ports
// Assumes: one clock domain, reset active low
// Notes:   attached to every sequencer instance by bind
`timescale 1ns/1ps
module seq_checker (
	// clock and reset
	input wire        core_clk_in,
	input wire        arst_n_in,
	// register bus
	input wire        s_axi_arvalid_in,
	input wire        s_axi_arready_out,
	input wire        s_axi_rvalid_out,
	input wire        s_axi_rready_in,
	input wire [31:0] s_axi_rdata_out,
	input wire [1:0]  s_axi_rresp_out,
	input wire        s_axi_bvalid_out,
	input wire        s_axi_bready_in,
	input wire [1:0]  s_axi_bresp_out,
	// terminal and interrupt
	input wire        xfer_done_in,
	input wire        xfer_ok_in,
	input wire        xfer_req_out,
	input wire [1:0]  xfer_kind_out,
	input wire        xfer_bus_sel_out,
	input wire [15:0] xfer_word0_out,
	input wire [15:0] xfer_word1_out,
	input wire        pci_out
);
	// --------------------------------------------------------------
	// failed tries of one instruction
	// --------------------------------------------------------------
	reg [2:0] tries;
	wire      ans = xfer_req_out && xfer_done_in;

	// a sync transfer opens every run, so it restarts the count
	always @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			tries <= 3'h0;
		else if (ans)
			tries <= xfer_ok_in ? 3'h0 : tries + 3'h1;
		else if (xfer_req_out && xfer_kind_out == 2'h2)
			tries <= 3'h0;
	end

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!arst_n_in);

	req_hold_a: assert property (xfer_req_out && !xfer_done_in |=>
		xfer_req_out && $stable({xfer_kind_out, xfer_bus_sel_out,
		xfer_word0_out, xfer_word1_out}))
		else $error("transfer request changed before its answer");
	req_drop_a: assert property (ans |=> !xfer_req_out)
		else $error("request still high after answer");
	retry_cap_a: assert property (tries <= 3'h4)
		else $error("more than three retries");
	bus_pick_a: assert property (xfer_req_out && xfer_kind_out != 2'h2
		|-> xfer_bus_sel_out == xfer_word0_out[11])
		else $error("bus select differs from instruction bit");
	pci_due_a: assert property (ans && xfer_ok_in && xfer_word0_out[10]
		&& xfer_kind_out != 2'h2 |-> ##2 pci_out)
		else $error("interrupt missing after good transfer");
	pci_cause_a: assert property (pci_out |-> $past(ans && xfer_ok_in
		&& xfer_word0_out[10], 2))
		else $error("interrupt without a good flagged transfer");
	pci_pulse_a: assert property (pci_out |=> !pci_out)
		else $error("interrupt longer than one cycle");
	b_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in
		|=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
		else $error("write response dropped early");
	r_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in
		|=> s_axi_rvalid_out && $stable({s_axi_rdata_out, s_axi_rresp_out}))
		else $error("read data dropped early");
	r_answer_a: assert property (s_axi_arvalid_in && s_axi_arready_out
		|=> s_axi_rvalid_out)
		else $error("read answer late");
endmodule

bind bus_minor_cycle_sequencer seq_checker chk_i (.core_clk_in,
	.arst_n_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rvalid_out,
	.s_axi_rready_in, .s_axi_rdata_out, .s_axi_rresp_out,
	.s_axi_bvalid_out, .s_axi_bready_in, .s_axi_bresp_out, .xfer_done_in,
	.xfer_ok_in, .xfer_req_out, .xfer_kind_out, .xfer_bus_sel_out,
	.xfer_word0_out, .xfer_word1_out, .pci_out);
